// *** shared/ecil_pkg.sv ***
package ecil_pkg;
  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] SFR_IRQ_ENABLE = 8'ha8;
  localparam logic [7:0] SFR_IRQ_PRIORITY = 8'hb8;
  localparam logic [15:0] XADR_REQ_A_SOURCE = 16'h7f00;
  localparam logic [15:0] XADR_REQ_A_MASK = 16'h7f01;
  localparam logic [15:0] XADR_REQ_B_SOURCE = 16'h7f02;
  localparam logic [15:0] XADR_REQ_B_MASK = 16'h7f03;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
  localparam logic [7:0] IRQ_PRIORITY_RST = 8'h00;
  localparam logic [7:0] REQ_SOURCE_RST = 8'h00;
  localparam logic [7:0] REQ_MASK_RST = 8'h00;
  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int NUM_SRC = 6;
  localparam int BIT_GLOBAL_GATE = 7;
  localparam logic [7:0] IRQ_ENABLE_WMASK = 8'hbf;
  localparam logic [7:0] IRQ_PRIORITY_WMASK = 8'h3f;
  localparam logic [7:0] REQ_A_WMASK = 8'h0f;
  localparam logic [7:0] REQ_B_RC_MASK = 8'h7d;
  // Source index order doubles as the polling order
  localparam int SRC_EXT_A = 0;
  localparam int SRC_TIMER0 = 1;
  localparam int SRC_EXT_B = 2;
  localparam int SRC_TIMER1 = 3;
  localparam int SRC_SERIAL = 4;
  localparam int SRC_WAKE = 5;
  // ---------------------------------------------------------------
  // Vectors
  // ---------------------------------------------------------------
  localparam logic [7:0] VEC_EXT_A = 8'h03;
  localparam logic [7:0] VEC_TIMER0 = 8'h0b;
  localparam logic [7:0] VEC_EXT_B = 8'h13;
  localparam logic [7:0] VEC_TIMER1 = 8'h1b;
  localparam logic [7:0] VEC_SERIAL = 8'h23;
  localparam logic [7:0] VEC_WAKE = 8'h2b;
  localparam logic [7:0] VEC_NONE = 8'h00;
  // Dispatcher states
  typedef enum logic [1:0] {
    ECIL_IDLE = 2'b01,
    ECIL_BUSY = 2'b10
  } ecil_state_t;
endpackage

// *** shared/ecil_src_if.sv ***
`timescale 1ns/1ns
// Carries one merged request line between its source register and the core
interface ecil_src_if #(parameter int W = 8);
  logic [W-1:0] event_set;
  logic rd_clear;
  logic [W-1:0] lvl_clear;
  logic [W-1:0] mask;
  logic [W-1:0] flags;
  logic request;
  modport regs (input event_set, input rd_clear, input lvl_clear, input mask,
    output flags, output request);
  modport user (output event_set, output rd_clear, output lvl_clear, output mask,
    input flags, input request);
endinterface

// *** hdl/ecil_src_reg.sv ***
`timescale 1ns/1ns
// Sticky source flags with clear-on-read and a mask gate
module ecil_src_reg
  import ecil_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] CLR_BITS = '1
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  ecil_src_if.regs sif
);
  logic [W-1:0] flags_q;
  logic [W-1:0] flags_d;

  // Set wins over the clearing read
  always_comb begin
    flags_d = flags_q;
    if (sif.rd_clear) begin
      flags_d = flags_q & ~CLR_BITS;
    end
    flags_d = flags_d & ~sif.lvl_clear;
    flags_d = flags_d | sif.event_set;
  end

  // Flag storage
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      flags_q <= W'(REQ_SOURCE_RST);
    end else begin
      flags_q <= flags_d;
    end
  end

  assign sif.flags = flags_q;
  assign sif.request = |(flags_q & ~sif.mask);
endmodule

// *** hdl/ecil_top.sv ***
`timescale 1ns/1ns
module ecil_top
  import ecil_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  // SFR port
  input wire logic [7:0] SFR_ADDR_IN,
  input wire logic SFR_WR_IN,
  input wire logic [7:0] SFR_WDATA_IN,
  output logic [7:0] SFR_RDATA_OUT,
  // External data port
  input wire logic [15:0] XDATA_ADDR_IN,
  input wire logic XDATA_WR_IN,
  input wire logic XDATA_RD_IN,
  input wire logic [7:0] XDATA_WDATA_IN,
  output logic [7:0] XDATA_RDATA_OUT,
  // Request line mode: 1 edge, 0 level
  input wire logic EXT_A_EDGE_MODE_IN,
  input wire logic EXT_B_EDGE_MODE_IN,
  // Same-clock peripheral sources
  input wire logic TIMER0_OVERFLOW_IN,
  input wire logic TIMER1_OVERFLOW_IN,
  input wire logic UART_RX_FLAG_IN,
  input wire logic UART_TX_FLAG_IN,
  input wire logic RX_DATA_CHANGE_IN,
  input wire logic WAKE_EVENT_IN,
  input wire logic [7:0] REQ_B_EVENT_IN,
  input wire logic [7:0] REQ_B_LEVEL_CLR_IN,
  // Pins
  input wire logic WAKE_INPUT_A_IN,
  input wire logic WAKE_INPUT_B_IN,
  input wire logic WAKE_INPUT_C_IN,
  // Core handshake
  input wire logic IRQ_ACK_IN,
  input wire logic IRQ_RETI_IN,
  output logic IRQ_REQ_OUT,
  output logic [7:0] IRQ_VECTOR_OUT,
  output logic IRQ_HIGH_OUT,
  output logic EXT_REQUEST_A_OUT,
  output logic EXT_REQUEST_B_OUT
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Vector for a source index
  function automatic logic [7:0] vec_of(input logic [2:0] idx);
    case (idx)
      3'h0: vec_of = VEC_EXT_A;
      3'h1: vec_of = VEC_TIMER0;
      3'h2: vec_of = VEC_EXT_B;
      3'h3: vec_of = VEC_TIMER1;
      3'h4: vec_of = VEC_SERIAL;
      3'h5: vec_of = VEC_WAKE;
      default: vec_of = VEC_NONE;
    endcase
  endfunction

  // Lowest set index wins; fixed polling order
  function automatic logic [2:0] first_of(input logic [NUM_SRC-1:0] v);
    first_of = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_of = 3'(i);
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  logic [7:0] irq_enable_q;
  logic [7:0] irq_priority_q;
  logic [7:0] req_a_mask_q;
  logic [7:0] req_b_mask_q;
  logic [2:0] wake_s1_q;
  logic [2:0] wake_s2_q;
  logic [2:0] wake_s3_q;
  logic ext_a_q;
  logic ext_b_q;
  logic ext_a_edge_q;
  logic ext_b_edge_q;
  logic serial_q;
  logic serial_pend_q;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] armed;
  logic [NUM_SRC-1:0] hi_set;
  logic [NUM_SRC-1:0] lo_set;
  logic [2:0] pick;
  logic pick_high;
  logic any_armed;
  logic in_hi_q;
  logic in_lo_q;
  logic can_take;
  ecil_state_t state_q;
  logic [7:0] vector_q;
  logic high_q;
  logic [7:0] sfr_rdata_q;
  logic [7:0] xdata_rdata_q;
  logic [3:0] wake_edge;
  logic [7:0] b_clear_d;

  ecil_src_if #(.W(8)) a_if ();
  ecil_src_if #(.W(8)) b_if ();

  // ---------------------------------------------------------------
  // SFR registers
  // ---------------------------------------------------------------
  // Enable register; D6 reserved
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      irq_enable_q <= IRQ_ENABLE_RST;
    end else if (SFR_WR_IN && SFR_ADDR_IN == SFR_IRQ_ENABLE) begin
      irq_enable_q <= SFR_WDATA_IN & IRQ_ENABLE_WMASK;
    end
  end

  // Priority register; D7-D6 reserved
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      irq_priority_q <= IRQ_PRIORITY_RST;
    end else if (SFR_WR_IN && SFR_ADDR_IN == SFR_IRQ_PRIORITY) begin
      irq_priority_q <= SFR_WDATA_IN & IRQ_PRIORITY_WMASK;
    end
  end

  // SFR read data
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      sfr_rdata_q <= 8'h00;
    end else if (SFR_ADDR_IN == SFR_IRQ_ENABLE) begin
      sfr_rdata_q <= irq_enable_q;
    end else if (SFR_ADDR_IN == SFR_IRQ_PRIORITY) begin
      sfr_rdata_q <= irq_priority_q;
    end else begin
      sfr_rdata_q <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Memory-mapped mask and source registers
  // ---------------------------------------------------------------
  // Mask registers
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      req_a_mask_q <= REQ_MASK_RST;
      req_b_mask_q <= REQ_MASK_RST;
    end else if (XDATA_WR_IN) begin
      if (XDATA_ADDR_IN == XADR_REQ_A_MASK) begin
        req_a_mask_q <= XDATA_WDATA_IN & REQ_A_WMASK;
      end else if (XDATA_ADDR_IN == XADR_REQ_B_MASK) begin
        req_b_mask_q <= XDATA_WDATA_IN;
      end
    end
  end

  // Read data; source registers identify the cause
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      xdata_rdata_q <= 8'h00;
    end else if (XDATA_RD_IN) begin
      if (XDATA_ADDR_IN == XADR_REQ_A_SOURCE) begin
        xdata_rdata_q <= a_if.flags;
      end else if (XDATA_ADDR_IN == XADR_REQ_A_MASK) begin
        xdata_rdata_q <= req_a_mask_q;
      end else if (XDATA_ADDR_IN == XADR_REQ_B_SOURCE) begin
        xdata_rdata_q <= b_if.flags;
      end else if (XDATA_ADDR_IN == XADR_REQ_B_MASK) begin
        xdata_rdata_q <= req_b_mask_q;
      end else begin
        xdata_rdata_q <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // Wake pin edge detection
  // ---------------------------------------------------------------
  // Two-stage sync, then a third stage for edge compare
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      wake_s1_q <= 3'h0;
      wake_s2_q <= 3'h0;
      wake_s3_q <= 3'h0;
    end else begin
      wake_s1_q <= {WAKE_INPUT_C_IN, WAKE_INPUT_A_IN, WAKE_INPUT_B_IN};
      wake_s2_q <= wake_s1_q;
      wake_s3_q <= wake_s2_q;
    end
  end

  // Source A: D3 rx change, D2 input c, D1 input a, D0 input b
  assign wake_edge = {RX_DATA_CHANGE_IN, wake_s2_q ^ wake_s3_q};

  assign a_if.event_set = {4'h0, wake_edge};
  assign a_if.rd_clear = XDATA_RD_IN && XDATA_ADDR_IN == XADR_REQ_A_SOURCE;
  assign a_if.mask = req_a_mask_q;
  assign a_if.lvl_clear = '0;

  // Source B: D1 and D7 clear by their own peripheral reads
  assign b_clear_d = REQ_B_LEVEL_CLR_IN & ~REQ_B_RC_MASK;
  assign b_if.event_set = REQ_B_EVENT_IN;
  assign b_if.rd_clear = XDATA_RD_IN && XDATA_ADDR_IN == XADR_REQ_B_SOURCE;
  assign b_if.mask = req_b_mask_q;
  assign b_if.lvl_clear = b_clear_d;

  ecil_src_reg #(.W(8), .CLR_BITS(REQ_A_WMASK)) u_src_a (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .sif(a_if.regs)
  );

  ecil_src_reg #(.W(8), .CLR_BITS(REQ_B_RC_MASK)) u_src_b (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .sif(b_if.regs)
  );

  // ---------------------------------------------------------------
  // Source conditioning
  // ---------------------------------------------------------------
  // Previous levels for edge modes
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      ext_a_q <= 1'b0;
      ext_b_q <= 1'b0;
      serial_q <= 1'b0;
    end else begin
      ext_a_q <= a_if.request;
      ext_b_q <= b_if.request;
      serial_q <= UART_RX_FLAG_IN | UART_TX_FLAG_IN;
    end
  end

  // Edge latches cleared when their vector is taken
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      ext_a_edge_q <= 1'b0;
      ext_b_edge_q <= 1'b0;
      serial_pend_q <= 1'b0;
    end else begin
      if (a_if.request && !ext_a_q) begin
        ext_a_edge_q <= 1'b1;
      end else if (IRQ_ACK_IN && state_q == ECIL_BUSY && vector_q == VEC_EXT_A) begin
        ext_a_edge_q <= 1'b0;
      end
      if (b_if.request && !ext_b_q) begin
        ext_b_edge_q <= 1'b1;
      end else if (IRQ_ACK_IN && state_q == ECIL_BUSY && vector_q == VEC_EXT_B) begin
        ext_b_edge_q <= 1'b0;
      end
      if ((UART_RX_FLAG_IN | UART_TX_FLAG_IN) && !serial_q) begin
        serial_pend_q <= 1'b1;
      end else if (IRQ_ACK_IN && state_q == ECIL_BUSY && vector_q == VEC_SERIAL) begin
        serial_pend_q <= 1'b0;
      end
    end
  end

  // Pending sources in polling order
  always_comb begin
    pend = '0;
    pend[SRC_EXT_A] = EXT_A_EDGE_MODE_IN ? ext_a_edge_q : a_if.request;
    pend[SRC_TIMER0] = TIMER0_OVERFLOW_IN;
    pend[SRC_EXT_B] = EXT_B_EDGE_MODE_IN ? ext_b_edge_q : b_if.request;
    pend[SRC_TIMER1] = TIMER1_OVERFLOW_IN;
    pend[SRC_SERIAL] = serial_pend_q;
    pend[SRC_WAKE] = WAKE_EVENT_IN;
  end

  // ---------------------------------------------------------------
  // Priority resolution and dispatch
  // ---------------------------------------------------------------
  assign armed = pend & irq_enable_q[NUM_SRC-1:0]
               & {NUM_SRC{irq_enable_q[BIT_GLOBAL_GATE]}};
  assign hi_set = armed & irq_priority_q[NUM_SRC-1:0];
  assign lo_set = armed & ~irq_priority_q[NUM_SRC-1:0];
  assign pick_high = |hi_set;
  assign pick = pick_high ? first_of(hi_set) : first_of(lo_set);
  assign any_armed = |armed;
  // High level preempts low; nothing preempts high
  assign can_take = pick_high ? !in_hi_q : !(in_hi_q || in_lo_q);

  // Dispatcher: present vector until the core acknowledges or the global gate closes
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      state_q <= ECIL_IDLE;
      vector_q <= VEC_NONE;
      high_q <= 1'b0;
    end else begin
      case (state_q)
        ECIL_IDLE: begin
          if (any_armed && can_take) begin
            state_q <= ECIL_BUSY;
            vector_q <= vec_of(pick);
            high_q <= pick_high;
          end
        end
        ECIL_BUSY: begin
          if (IRQ_ACK_IN) begin
            state_q <= ECIL_IDLE;
          end else if (!irq_enable_q[BIT_GLOBAL_GATE]) begin
            state_q <= ECIL_IDLE;
          end
        end
        default: state_q <= ECIL_IDLE;
      endcase
    end
  end

  // In-service levels, released on return
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      in_hi_q <= 1'b0;
      in_lo_q <= 1'b0;
    end else if (state_q == ECIL_BUSY && IRQ_ACK_IN) begin
      if (high_q) begin
        in_hi_q <= 1'b1;
      end else begin
        in_lo_q <= 1'b1;
      end
    end else if (IRQ_RETI_IN) begin
      if (in_hi_q) begin
        in_hi_q <= 1'b0;
      end else begin
        in_lo_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign IRQ_REQ_OUT = state_q == ECIL_BUSY;
  assign IRQ_VECTOR_OUT = vector_q;
  assign IRQ_HIGH_OUT = high_q;
  assign EXT_REQUEST_A_OUT = a_if.request;
  assign EXT_REQUEST_B_OUT = b_if.request;
  assign SFR_RDATA_OUT = sfr_rdata_q;
  assign XDATA_RDATA_OUT = xdata_rdata_q;
endmodule

// *** testbench/ecil_top_properties.sv ***
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Port-level checks of the interrupt logic
// ---------------------------------------------------------------
module ecil_top_properties
  import ecil_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic [7:0] SFR_ADDR_IN,
  input wire logic SFR_WR_IN,
  input wire logic [7:0] SFR_WDATA_IN,
  input wire logic [7:0] SFR_RDATA_OUT,
  input wire logic [15:0] XDATA_ADDR_IN,
  input wire logic XDATA_WR_IN,
  input wire logic XDATA_RD_IN,
  input wire logic [7:0] XDATA_WDATA_IN,
  input wire logic [7:0] XDATA_RDATA_OUT,
  input wire logic IRQ_ACK_IN,
  input wire logic IRQ_REQ_OUT,
  input wire logic [7:0] IRQ_VECTOR_OUT,
  input wire logic IRQ_HIGH_OUT,
  input wire logic EXT_REQUEST_A_OUT
);
  logic [7:0] en_q, ip_q, mask_q;
  wire logic [2:0] vidx = IRQ_VECTOR_OUT[5:3];
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  // Shadow of enable and priority registers
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      en_q <= 8'h00;
      ip_q <= 8'h00;
    end else if (SFR_WR_IN && SFR_ADDR_IN == SFR_IRQ_ENABLE) begin
      en_q <= SFR_WDATA_IN & 8'hbf;
    end else if (SFR_WR_IN && SFR_ADDR_IN == SFR_IRQ_PRIORITY) begin
      ip_q <= SFR_WDATA_IN & 8'h3f;
    end
  end
  // Shadow of the request A mask
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      mask_q <= 8'h00;
    end else if (XDATA_WR_IN && XDATA_ADDR_IN == XADR_REQ_A_MASK) begin
      mask_q <= XDATA_WDATA_IN & 8'h0f;
    end
  end
  gate_block_a: assert property ($rose(IRQ_REQ_OUT) |->
    $past(en_q[7]) || $past(en_q[7], 2)) else $error("request raised with gate closed");
  vec_legal_a: assert property (IRQ_REQ_OUT |-> IRQ_VECTOR_OUT inside
    {8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b}) else $error("illegal vector");
  vec_enabled_a: assert property ($rose(IRQ_REQ_OUT) |-> en_q[vidx])
    else $error("vector of a disabled source");
  high_level_a: assert property ($rose(IRQ_REQ_OUT) |-> IRQ_HIGH_OUT == ip_q[vidx])
    else $error("priority flag mismatch");
  sfr_read_a: assert property (!SFR_WR_IN ##1 !SFR_WR_IN && $stable(SFR_ADDR_IN) |->
    SFR_RDATA_OUT == (SFR_ADDR_IN == 8'ha8 ? en_q : SFR_ADDR_IN == 8'hb8 ? ip_q : 8'h00))
    else $error("sfr read data mismatch");
  mask_read_a: assert property (XDATA_RD_IN && !XDATA_WR_IN &&
    XDATA_ADDR_IN == 16'h7f01 |=> XDATA_RDATA_OUT == mask_q) else $error("mask read mismatch");
  src_resv_a: assert property (XDATA_RD_IN && XDATA_ADDR_IN == 16'h7f00 |=>
    XDATA_RDATA_OUT[7:4] == 4'h0) else $error("source reserved bits set");
  mask_block_a: assert property (mask_q[3:0] == 4'hf |-> !EXT_REQUEST_A_OUT)
    else $error("masked request passed");
  req_hold_a: assert property (IRQ_REQ_OUT && !IRQ_ACK_IN && en_q[7] && !SFR_WR_IN
    |=> IRQ_REQ_OUT) else $error("request dropped before ack");
  ack_drop_a: assert property (IRQ_ACK_IN && IRQ_REQ_OUT |=> !IRQ_REQ_OUT)
    else $error("request held after ack");
  vec_stable_a: assert property (IRQ_REQ_OUT && !IRQ_ACK_IN |=>
    $stable(IRQ_VECTOR_OUT) || !IRQ_REQ_OUT) else $error("vector moved while pending");
endmodule
bind ecil_top ecil_top_properties ecil_top_properties_inst (.*);

// *** testbench/ecil_core_model.sv ***
`timescale 1ns/1ns
// Core side: takes a vector promptly or late, runs a handler, then returns
module ecil_core_model #(
  parameter int HANDLER_CYCLES = 6
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic slow_in,
  input wire logic irq_req_in,
  output logic irq_ack_out,
  output logic irq_reti_out
);
  // Acknowledge and return sequencer
  initial begin
    irq_ack_out = 1'h0;
    irq_reti_out = 1'h0;
    forever begin
      @(posedge clk_in);
      #1;
      if (rstn_in && irq_req_in) begin
        if (slow_in) begin
          repeat (4) @(posedge clk_in);
          #1;
        end
        irq_ack_out = 1'h1;
        @(posedge clk_in);
        #1;
        irq_ack_out = 1'h0;
        repeat (HANDLER_CYCLES) @(posedge clk_in);
        #1;
        irq_reti_out = 1'h1;
        @(posedge clk_in);
        #1;
        irq_reti_out = 1'h0;
      end
    end
  end
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_top
  import ecil_pkg::*;
;
  logic clk = 1'h0, rstn = 1'h0, sfr_wr = 1'h0, x_wr = 1'h0, x_rd = 1'h0, slow = 1'h0;
  logic t0 = 1'h0, t1 = 1'h0, urx = 1'h0, utx = 1'h0, rxchg = 1'h0, wake_ev = 1'h0;
  logic pin_a = 1'h0, pin_b = 1'h0, pin_c = 1'h0, ack, reti, req, high, ext_a, ext_b;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, x_wdata = 8'h00, req_b_ev = 8'h00;
  logic [7:0] sfr_rdata, x_rdata, vec;
  logic [15:0] x_addr = 16'h0000;
  logic [7:0] taken[$];
  int fail_count = 0, checked = 0;
  logic edge_mode = 1'h1;
  logic [7:0] b_lvl_clr = 8'h00;
  logic [7:0] pin_bits[3] = '{8'h02, 8'h01, 8'h04};
  ecil_top ecil_top_inst (.CLK_IN(clk), .RSTN_IN(rstn), .SFR_ADDR_IN(sfr_addr),
    .SFR_WR_IN(sfr_wr), .SFR_WDATA_IN(sfr_wdata), .SFR_RDATA_OUT(sfr_rdata),
    .XDATA_ADDR_IN(x_addr), .XDATA_WR_IN(x_wr), .XDATA_RD_IN(x_rd), .XDATA_WDATA_IN(x_wdata),
    .XDATA_RDATA_OUT(x_rdata), .EXT_A_EDGE_MODE_IN(edge_mode), .EXT_B_EDGE_MODE_IN(edge_mode),
    .TIMER0_OVERFLOW_IN(t0), .TIMER1_OVERFLOW_IN(t1), .UART_RX_FLAG_IN(urx),
    .UART_TX_FLAG_IN(utx), .RX_DATA_CHANGE_IN(rxchg), .WAKE_EVENT_IN(wake_ev),
    .REQ_B_EVENT_IN(req_b_ev), .REQ_B_LEVEL_CLR_IN(b_lvl_clr), .WAKE_INPUT_A_IN(pin_a),
    .WAKE_INPUT_B_IN(pin_b), .WAKE_INPUT_C_IN(pin_c), .IRQ_ACK_IN(ack), .IRQ_RETI_IN(reti),
    .IRQ_REQ_OUT(req), .IRQ_VECTOR_OUT(vec), .IRQ_HIGH_OUT(high), .EXT_REQUEST_A_OUT(ext_a),
    .EXT_REQUEST_B_OUT(ext_b));
  ecil_core_model ecil_core_model_inst (.clk_in(clk), .rstn_in(rstn), .slow_in(slow),
    .irq_req_in(req), .irq_ack_out(ack), .irq_reti_out(reti));
  // ---------------------------------------------------------------
  // Clock, vector log and watchdog
  // ---------------------------------------------------------------
  always #5 clk = ~clk;
  // Log each taken vector; firmware then clears the timer or wake source it served
  always @(posedge clk) begin
    if (rstn && ack) begin
      taken.push_back(vec);
      #1;
      case (taken[$])
        VEC_TIMER0: t0 = 1'h0;
        VEC_TIMER1: t1 = 1'h0;
        VEC_WAKE: wake_ev = 1'h0;
        default: ;
      endcase
    end
  end
  // Cuts a hung run short
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'h1;
    tick();
    sfr_wr = 1'h0;
    tick();
  endtask
  task automatic sfr_chk(input logic [7:0] a, input logic [7:0] ex, input string nm);
    sfr_addr = a;
    tick(2);
    `CHK(nm, ex, sfr_rdata)
  endtask
  task automatic x_write(input logic [15:0] a, input logic [7:0] d);
    x_addr = a;
    x_wdata = d;
    x_wr = 1'h1;
    tick();
    x_wr = 1'h0;
    tick();
  endtask
  task automatic x_chk(input logic [15:0] a, input logic [7:0] ex, input string nm);
    x_addr = a;
    x_rd = 1'h1;
    tick();
    x_rd = 1'h0;
    `CHK(nm, ex, x_rdata)
    tick();
  endtask
  // Toggle one wake pin, then check the merged request and the source flag
  task automatic pin_edge(input int p, input logic [7:0] ex, input logic rq);
    case (p)
      0: pin_a = ~pin_a;
      1: pin_b = ~pin_b;
      default: pin_c = ~pin_c;
    endcase
    tick(5);
    `CHK("request a", rq, ext_a)
    x_chk(XADR_REQ_A_SOURCE, ex, "wake source");
  endtask
  // Raise all six sources with the gate closed, then open it and log the order
  task automatic round(input logic [7:0] pri, input logic [7:0] ord[6], input logic tx);
    sfr_write(SFR_IRQ_ENABLE, 8'h3f);
    sfr_write(SFR_IRQ_PRIORITY, pri);
    taken.delete();
    slow = tx;
    rxchg = 1'h1;
    req_b_ev = 8'h83;
    t0 = 1'h1;
    t1 = 1'h1;
    wake_ev = 1'h1;
    if (tx) utx = 1'h1;
    else urx = 1'h1;
    tick();
    rxchg = 1'h0;
    req_b_ev = 8'h00;
    tick(10);
    `CHK("taken while gated", 0, taken.size())
    `CHK("request b", 1'h1, ext_b)
    sfr_write(SFR_IRQ_ENABLE, 8'hbf);
    tick(200);
    `CHK("taken count", 6, taken.size())
    foreach (ord[i]) `CHK("vector", ord[i], taken[i])
    x_chk(XADR_REQ_A_SOURCE, 8'h08, "source a");
    x_chk(XADR_REQ_B_SOURCE, 8'h83, "source b");
    x_chk(XADR_REQ_B_SOURCE, 8'h82, "source b kept");
    b_lvl_clr = 8'hff;
    tick();
    b_lvl_clr = 8'h00;
    `CHK("request b cleared", 1'h0, ext_b)
    x_chk(XADR_REQ_B_SOURCE, 8'h00, "source b level clear");
    x_chk(XADR_REQ_A_SOURCE, 8'h00, "source a cleared");
    urx = 1'h0;
    utx = 1'h0;
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    tick(4);
    rstn = 1'h1;
    tick();
    sfr_chk(SFR_IRQ_ENABLE, 8'h00, "enable reset");
    sfr_chk(SFR_IRQ_PRIORITY, 8'h00, "priority reset");
    x_chk(XADR_REQ_A_MASK, 8'h00, "mask reset");
    x_chk(XADR_REQ_A_SOURCE, 8'h00, "source reset");
    sfr_write(SFR_IRQ_ENABLE, 8'hff);
    sfr_chk(SFR_IRQ_ENABLE, 8'hbf, "enable bits");
    sfr_write(SFR_IRQ_PRIORITY, 8'hff);
    sfr_chk(SFR_IRQ_PRIORITY, 8'h3f, "priority bits");
    sfr_chk(8'hc0, 8'h00, "unmapped sfr");
    x_write(XADR_REQ_A_MASK, 8'hff);
    x_chk(XADR_REQ_A_MASK, 8'h0f, "mask bits");
    x_chk(16'h7f10, 8'h00, "unmapped xdata");
    x_write(XADR_REQ_A_MASK, 8'h00);
    sfr_write(SFR_IRQ_ENABLE, 8'h00);
    sfr_write(SFR_IRQ_PRIORITY, 8'h00);
    for (int i = 0; i < 6; i++) pin_edge(i % 3, pin_bits[i % 3], 1'h1);
    x_write(XADR_REQ_A_MASK, 8'h04);
    pin_edge(2, 8'h04, 1'h0);
    x_write(XADR_REQ_A_MASK, 8'h00);
    x_addr = XADR_REQ_A_SOURCE;
    x_rd = 1'h1;
    rxchg = 1'h1;
    tick();
    x_rd = 1'h0;
    rxchg = 1'h0;
    tick();
    x_chk(XADR_REQ_A_SOURCE, 8'h08, "set over clear");
    // Level mode: a masked level is not pending, an unmasked one retriggers
    edge_mode = 1'h0;
    rxchg = 1'h1;
    tick();
    rxchg = 1'h0;
    x_write(XADR_REQ_A_MASK, 8'h08);
    sfr_write(SFR_IRQ_ENABLE, 8'h81);
    tick(20);
    `CHK("masked level", 0, taken.size())
    x_write(XADR_REQ_A_MASK, 8'h00);
    tick(40);
    `CHK("level retrigger", 1'h1, taken.size() > 1)
    `CHK("level vector", VEC_EXT_A, taken[0])
    sfr_write(SFR_IRQ_ENABLE, 8'h00);
    x_chk(XADR_REQ_A_SOURCE, 8'h08, "level source");
    edge_mode = 1'h1;
    tick(20);
    round(8'h00, '{VEC_EXT_A, VEC_TIMER0, VEC_EXT_B, VEC_TIMER1, VEC_SERIAL, VEC_WAKE},
      1'h0);
    round(8'h20, '{VEC_WAKE, VEC_EXT_A, VEC_TIMER0, VEC_EXT_B, VEC_TIMER1, VEC_SERIAL},
      1'h1);
    tally_and_finish();
  end
endmodule
